// ### pkg/uphyc_consts.svh
// Notes on behaviour
// [RQ1] power word: data 7:0, valid 8, reset zero
// [RQ2] bit 18 disables pulldowns on both ports
// [RQ3] se0 auto-resume sets bit 13, software clears
// [RQ4] k auto-resume sets bit 12, software clears
// [RQ5] linestate change delayed two-power bits 11:8 clocks
// [RQ6] bit 7 selects hardware resume or polling
// [RQ7] bits 6:4 drive transceiver config pins
// [RQ8] reserved bits read zero, writes ignored
`ifndef UPHYC_CONSTS_SVH
`define UPHYC_CONSTS_SVH
`define UPHYC_OFF_PWR 8'h3C
`define UPHYC_OFF_PHY 8'h40
`define UPHYC_RST_WORD 32'h0000_0000
`define UPHYC_PWR_MASK 32'h0000_01FF
`define UPHYC_PHY_MASK 32'h0004_3FF0
`define UPHYC_BIT_PD 18
`define UPHYC_BIT_SE0 13
`define UPHYC_BIT_K 12
`define UPHYC_DEB_HI 11
`define UPHYC_DEB_LO 8
`define UPHYC_BIT_HWRES 7
`define UPHYC_CFG_HI 6
`define UPHYC_CFG_LO 4
`define UPHYC_LS_J 2'h1
`define UPHYC_LS_K 2'h2
`define UPHYC_LS_SE0 2'h0
`endif

// ### pkg/uphyc_pkg.sv
package uphyc_pkg;
  // line state as seen on the wire
  typedef logic [1:0] uphyc_ls_t;
  // suspend controller states
  typedef enum logic [1:0] {
    UPHYC_AWAKE = 2'b00,
    UPHYC_SUSP = 2'b01,
    UPHYC_WAKE = 2'b10
  } uphyc_st_t;
endpackage

// ### pkg/uphyc_deb_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries linestate between top and debounce filter
interface uphyc_deb_if;
  import uphyc_pkg::*;
  uphyc_ls_t raw; // synchronised line
  logic [3:0] log2_len; // debounce exponent
  uphyc_ls_t filt; // filtered line
  modport filt_side (input raw, input log2_len, output filt);
  modport top_side (output raw, output log2_len, input filt);
endinterface
`default_nettype wire

// ### design/uphyc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "uphyc_consts.svh"
module uphyc_debounce (
  input wire logic i_clk,
  input wire logic i_nrst,
  uphyc_deb_if.filt_side d
);
  import uphyc_pkg::*;
  logic [15:0] cnt_q; // cycles raw has differed from filt_q
  uphyc_ls_t filt_q; // filtered output
  logic [15:0] len; // required stable length
  assign len = 16'h0001 << d.log2_len;
  assign d.filt = filt_q;
  // count while raw differs, update after the full delay
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q <= 16'h0000;
      filt_q <= 2'h1;
    end else if (d.raw == filt_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= len) begin // [RQ5]
      filt_q <= d.raw;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // a change appears no earlier than the delay
  a_deb_min_delay: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ5]
    (filt_q != $past(filt_q)) |-> ($past(cnt_q) + 16'h0001 >= $past(len)))
    else $error("filtered linestate updated early");
  // no change while raw matches
  a_deb_stable: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RQ5]
    ($past(d.raw) == $past(filt_q)) |-> $stable(filt_q))
    else $error("filtered linestate moved without cause");
endmodule
`default_nettype wire

// ### design/uphyc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "uphyc_consts.svh"
module uphyc_regs (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire uphyc_pkg::uphyc_ls_t I_LINESTATE,
  input wire logic I_SUSPENDED,
  output logic [7:0] O_PWR_DATA,
  output logic O_PWR_VALID,
  output logic O_PD_DIS_PORT_A,
  output logic O_PD_DIS_PORT_B,
  output logic [2:0] O_XCVR_CONFIG,
  output logic O_HW_RESUME_EN,
  output logic O_RESUME_REQ,
  output uphyc_pkg::uphyc_ls_t O_LINESTATE_FILT
);
  import uphyc_pkg::*;
  logic [31:0] pwr_q; // power signalling word
  logic [31:0] phy_q; // phy control word
  logic [31:0] rdata_q; // registered read data
  uphyc_ls_t ls_s1_q; // synchroniser stage one
  uphyc_ls_t ls_s2_q; // synchroniser stage two
  uphyc_st_t st_q; // suspend controller state
  logic set_se0; // se0 auto-resume event
  logic set_k; // k auto-resume event
  logic wr_pwr; // write hits power word
  logic wr_phy; // write hits phy word
  uphyc_deb_if deb ();
  assign wr_pwr = I_WR && (I_ADDR == `UPHYC_OFF_PWR);
  assign wr_phy = I_WR && (I_ADDR == `UPHYC_OFF_PHY);
  // linestate pin into clock domain
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ls_s1_q <= 2'h1;
      ls_s2_q <= 2'h1;
    end else begin
      ls_s1_q <= I_LINESTATE;
      ls_s2_q <= ls_s1_q;
    end
  end
  assign deb.raw = ls_s2_q;
  assign deb.log2_len = phy_q[`UPHYC_DEB_HI:`UPHYC_DEB_LO]; // [RQ5]
  uphyc_debounce u_deb (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .d(deb.filt_side)
  );
  assign O_LINESTATE_FILT = deb.filt;
  // power word storage, reserved bits masked
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      pwr_q <= `UPHYC_RST_WORD; // [RQ1]
    end else if (wr_pwr) begin
      pwr_q <= I_WDATA & `UPHYC_PWR_MASK; // [RQ1] [RQ8]
    end
  end
  // suspend controller: wake on k or se0 when enabled
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      st_q <= UPHYC_AWAKE;
    end else begin
      case (st_q)
        UPHYC_AWAKE: begin
          if (I_SUSPENDED && phy_q[`UPHYC_BIT_HWRES]) begin // [RQ6]
            st_q <= UPHYC_SUSP;
          end
        end
        UPHYC_SUSP: begin
          if (!phy_q[`UPHYC_BIT_HWRES]) begin // software polls instead
            st_q <= UPHYC_AWAKE;
          end else if (set_se0 || set_k) begin
            st_q <= UPHYC_WAKE;
          end
        end
        UPHYC_WAKE: begin
          if (!I_SUSPENDED) begin
            st_q <= UPHYC_AWAKE;
          end
        end
        default: begin
          st_q <= UPHYC_AWAKE;
        end
      endcase
    end
  end
  // wake events only while armed in hardware mode, so polling never sets flags
  assign set_se0 = (st_q == UPHYC_SUSP) && phy_q[`UPHYC_BIT_HWRES] &&
    (deb.filt == `UPHYC_LS_SE0);
  assign set_k = (st_q == UPHYC_SUSP) && phy_q[`UPHYC_BIT_HWRES] &&
    (deb.filt == `UPHYC_LS_K);
  // phy word storage, event set wins over clear
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      phy_q <= `UPHYC_RST_WORD;
    end else begin
      if (wr_phy) begin
        phy_q <= I_WDATA & `UPHYC_PHY_MASK; // [RQ8]
      end
      if (set_se0) begin
        phy_q[`UPHYC_BIT_SE0] <= 1'b1; // [RQ3]
      end
      if (set_k) begin
        phy_q[`UPHYC_BIT_K] <= 1'b1; // [RQ4]
      end
    end
  end
  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (I_RD && I_ADDR == `UPHYC_OFF_PWR) begin
      rdata_q <= pwr_q;
    end else if (I_RD && I_ADDR == `UPHYC_OFF_PHY) begin
      rdata_q <= phy_q;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign O_RDATA = rdata_q;
  // outputs straight from register bits, resume request decoded from controller state
  assign O_PWR_DATA = pwr_q[7:0];
  assign O_PWR_VALID = pwr_q[8];
  assign O_PD_DIS_PORT_A = phy_q[`UPHYC_BIT_PD]; // [RQ2]
  assign O_PD_DIS_PORT_B = phy_q[`UPHYC_BIT_PD]; // [RQ2]
  assign O_XCVR_CONFIG = phy_q[`UPHYC_CFG_HI:`UPHYC_CFG_LO]; // [RQ7]
  assign O_HW_RESUME_EN = phy_q[`UPHYC_BIT_HWRES]; // [RQ6]
  assign O_RESUME_REQ = (st_q == UPHYC_WAKE); // [RQ6]
  // power word write shows next cycle
  a_pwr_write: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ1]
    wr_pwr |=> (pwr_q == ($past(I_WDATA) & `UPHYC_PWR_MASK)))
    else $error("power word not written");
  // power word holds between writes
  a_pwr_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ1]
    !wr_pwr |=> $stable(pwr_q))
    else $error("power word changed without a write");
  // pulldown outputs follow bit 18
  a_pd_follow: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ2]
    wr_phy |=> (O_PD_DIS_PORT_A == $past(I_WDATA[`UPHYC_BIT_PD]) &&
      O_PD_DIS_PORT_B == O_PD_DIS_PORT_A))
    else $error("pulldown disable wrong");
  // se0 event sets bit 13 even during a clear
  a_se0_sticky: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ3]
    set_se0 |=> phy_q[`UPHYC_BIT_SE0])
    else $error("se0 resume flag not set");
  // k event sets bit 12
  a_k_sticky: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ4]
    set_k |=> phy_q[`UPHYC_BIT_K])
    else $error("k resume flag not set");
  // se0 flag holds unless written
  a_flag_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ3]
    (phy_q[`UPHYC_BIT_SE0] && !wr_phy) |=> phy_q[`UPHYC_BIT_SE0])
    else $error("se0 resume flag dropped");
  // k flag holds unless written
  a_k_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ4]
    (phy_q[`UPHYC_BIT_K] && !wr_phy) |=> phy_q[`UPHYC_BIT_K])
    else $error("k resume flag dropped");
  // writing zero clears the se0 flag when no event competes
  a_se0_clear: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ3]
    (wr_phy && !I_WDATA[`UPHYC_BIT_SE0] && !set_se0) |=> !phy_q[`UPHYC_BIT_SE0])
    else $error("se0 resume flag not cleared");
  // writing zero clears the k flag when no event competes
  a_k_clear: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ4]
    (wr_phy && !I_WDATA[`UPHYC_BIT_K] && !set_k) |=> !phy_q[`UPHYC_BIT_K])
    else $error("k resume flag not cleared");
  // no hardware wake when disabled
  a_poll_mode: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ6]
    !phy_q[`UPHYC_BIT_HWRES] |=> (st_q != UPHYC_SUSP) || phy_q[`UPHYC_BIT_HWRES])
    else $error("suspend controller active in poll mode");
  // hardware mode enters suspend with the far side
  a_susp_entry: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ6]
    ((st_q == UPHYC_AWAKE) && I_SUSPENDED && phy_q[`UPHYC_BIT_HWRES])
      |=> (st_q == UPHYC_SUSP))
    else $error("suspend controller did not arm");
  // wake ends once the far side leaves suspend
  a_wake_exit: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ6]
    ((st_q == UPHYC_WAKE) && !I_SUSPENDED) |=> (st_q == UPHYC_AWAKE))
    else $error("suspend controller stuck in wake");
  // resume steps: armed suspend sees an event, then the request stands
  sequence s_armed_event;
    (st_q == UPHYC_SUSP) && phy_q[`UPHYC_BIT_HWRES] && (set_se0 || set_k);
  endsequence
  sequence s_wake_hold;
    O_RESUME_REQ ##1 (O_RESUME_REQ || (st_q == UPHYC_AWAKE));
  endsequence
  a_resume_req: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ6]
    s_armed_event |=> s_wake_hold)
    else $error("resume request missing after wake event");
  // config pins follow written field
  a_cfg_pins: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ7]
    wr_phy |=> (O_XCVR_CONFIG == $past(I_WDATA[`UPHYC_CFG_HI:`UPHYC_CFG_LO])))
    else $error("config pins wrong");
  // config pins change only on writes
  a_cfg_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ7]
    !wr_phy |=> $stable(O_XCVR_CONFIG))
    else $error("config pins moved without a write");
  // reserved bits and unmapped addresses read zero
  a_rsvd_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ8]
    I_RD |=> ((O_RDATA & ~(($past(I_ADDR) == `UPHYC_OFF_PWR) ? `UPHYC_PWR_MASK :
      (($past(I_ADDR) == `UPHYC_OFF_PHY) ? `UPHYC_PHY_MASK : 32'h0000_0000)))
      == 32'h0000_0000))
    else $error("reserved bits nonzero");
  // read data stand one cycle, zero otherwise
  a_rdata_idle: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ8]
    !I_RD |=> (O_RDATA == 32'h0000_0000))
    else $error("read data without a read strobe");
  // power word read returns the stored value
  a_rd_pwr: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ1]
    (I_RD && I_ADDR == `UPHYC_OFF_PWR) |=> (O_RDATA == $past(pwr_q)))
    else $error("power word read wrong");
  // phy word read returns the stored value
  a_rd_phy: assert property (@(posedge I_CLK) disable iff (!I_NRST) // [RQ8]
    (I_RD && I_ADDR == `UPHYC_OFF_PHY) |=> (O_RDATA == $past(phy_q)))
    else $error("phy word read wrong");
endmodule
`default_nettype wire

// ### tb/uphyc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side transceiver: drives line state and suspend level
module uphyc_phy_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_ls_cmd,
  input wire logic i_susp_cmd,
  input wire logic i_resume_req,
  output logic [1:0] o_linestate,
  output logic o_suspended
);
  // line idles at j in reset, suspend level follows the command and drops while resume is requested
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_linestate <= 2'h1;
      o_suspended <= 1'b0;
    end else begin
      o_linestate <= i_ls_cmd;
      o_suspended <= i_susp_cmd & ~i_resume_req;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_usb_phy_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "uphyc_consts.svh"
module tb_usb_phy_control_regs;
  import uphyc_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, susp_cmd = 0;
  logic [7:0] addr = 8'h00, pwr_data;
  logic [31:0] wdata = 32'h0, rdata;
  uphyc_ls_t ls_cmd = 2'h1, ls, filt;
  logic suspended, pwr_valid, pd_a, pd_b, hw_en, resume_req;
  logic [2:0] cfg;
  int fails = 0, comparisons = 0, reqs = 0, base = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  uphyc_regs DUT (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_LINESTATE(ls),
    .I_SUSPENDED(suspended), .O_PWR_DATA(pwr_data), .O_PWR_VALID(pwr_valid),
    .O_PD_DIS_PORT_A(pd_a), .O_PD_DIS_PORT_B(pd_b), .O_XCVR_CONFIG(cfg),
    .O_HW_RESUME_EN(hw_en), .O_RESUME_REQ(resume_req), .O_LINESTATE_FILT(filt));
  uphyc_phy_model phy (.i_clk(clk), .i_nrst(nrst), .i_ls_cmd(ls_cmd),
    .i_susp_cmd(susp_cmd), .i_resume_req(resume_req), .o_linestate(ls),
    .o_suspended(suspended));
  // count cycles with a resume request
  always @(posedge clk) if (resume_req === 1'b1) reqs <= reqs + 1;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task results;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cases: resume line state and the flag it sets
  uphyc_ls_t res_ls [2] = '{2'h2, 2'h0};
  logic [31:0] res_bit [2] = '{32'h1000, 32'h2000};
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h3C, 32'h0);
    rd_reg(8'h40, 32'h0);
    chk({30'h0, filt}, 32'h1);
    wr_reg(8'h3C, 32'hFFFF_FFFF);
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_reg(8'h3C, 32'h1FF);
    rd_reg(8'h40, 32'h43FF0);
    chk({21'h0, pd_b, pd_a, pwr_valid, pwr_data}, 32'h7FF);
    chk({28'h0, hw_en, cfg}, 32'hF);
    rd_reg(8'h44, 32'h0);
    // debounce of four cycles behind one model flop and two sync flops
    wr_reg(8'h40, 32'h200);
    rd_reg(8'h40, 32'h200);
    chk({26'h0, pd_b, pd_a, hw_en, cfg}, 32'h0);
    ticks(20);
    ls_cmd <= 2'h2;
    ticks(6);
    @(negedge clk);
    chk({30'h0, filt}, 32'h1);
    ticks(1);
    @(negedge clk);
    chk({30'h0, filt}, 32'h2);
    // hardware resume by k then by se0
    for (int i = 0; i < 2; i++) begin
      base = reqs;
      @(posedge clk);
      ls_cmd <= 2'h1;
      wr_reg(8'h40, 32'h80);
      ticks(6);
      susp_cmd <= 1'b1;
      ticks(6);
      ls_cmd <= res_ls[i];
      ticks(10);
      rd_reg(8'h40, 32'h80 | res_bit[i]);
      chk({31'h0, reqs > base}, 32'h1);
      @(posedge clk);
      susp_cmd <= 1'b0;
      ls_cmd <= 2'h1;
      ticks(6);
      wr_reg(8'h40, 32'h80);
      rd_reg(8'h40, 32'h80);
    end
    // polled mode leaves the suspend controller idle, software sees the line
    base = reqs;
    wr_reg(8'h40, 32'h0);
    susp_cmd <= 1'b1;
    ticks(6);
    ls_cmd <= 2'h2;
    ticks(10);
    rd_reg(8'h40, 32'h0);
    chk({31'h0, reqs == base}, 32'h1);
    chk({30'h0, filt}, 32'h2);
    results();
  end
  // watchdog
  initial begin
    #200us;
    fails++;
    results();
  end
endmodule
`default_nettype wire
